//--- sorc_map.svh
// constants: timing counts, encodings and reset values of the safety output restart control
`ifndef SORC_MAP_SVH
`define SORC_MAP_SVH
`define SORC_CLK_HZ         50000000
`define SORC_DELAY_MIN_S    2
`define SORC_DELAY_MAX_S    60
`define SORC_FB_WAIT_MS     100
`define SORC_FB_WAIT_CYC    ((`SORC_CLK_HZ / 1000) * `SORC_FB_WAIT_MS)
`define SORC_ERR_NONE       8'h00
`define SORC_ERR_LOCKOUT    8'he1
`define SORC_ERR_CONTACTOR  8'he2
`define SORC_ERR_SELECT     8'he3
`endif

//--- sorc_pkg.sv
// package: types of the safety output restart control
package sorc_pkg;
   typedef enum logic [1:0] {
      SORC_RST_NONE      = 2'h0,
      SORC_RST_DELAY     = 2'h1,
      SORC_RST_INTERLOCK = 2'h2
   } sorc_restart_t;

   typedef enum logic [3:0] {
      SORC_ON     = 4'b0001,
      SORC_OFF    = 4'b0010,
      SORC_WAIT   = 4'b0100,
      SORC_LOCK   = 4'b1000
   } sorc_state_t;

   typedef struct packed {
      logic a1;
      logic a2;
      logic b1;
      logic b2;
   } sorc_lines_t;

   typedef struct packed {
      logic output_active;
      logic pf1_clear;
      logic pf2_clear;
      logic sim_pf1_clear;
      logic sim_pf2_clear;
      logic wf_clear;
      logic sim_wf_clear;
   } sorc_link_t;
endpackage

//--- sorc_top.sv
// design: one-hot case decode, output pair switching, feedback monitor, restart control
`timescale 1ns/1ns
`default_nettype none
`include "sorc_map.svh"
module sorc_top #(
   parameter int DELAY_S    = 2,
   parameter int CLK_HZ     = `SORC_CLK_HZ,
   parameter int FB_WAIT    = `SORC_FB_WAIT_CYC
) (
   // clock and reset
   input  wire  logic               clk,
   input  wire  logic               rst_n,
   // pins from outside
   input  wire  sorc_pkg::sorc_lines_t case_lines,
   input  wire  logic               reset_switch,
   input  wire  logic               contactor_fb,
   // field status from the measurement core, 1 = infringed; field_evaluated 1 = evaluated
   input  wire  logic               pf1_hit,
   input  wire  logic               pf2_hit,
   input  wire  logic               sim_pf1_hit,
   input  wire  logic               sim_pf2_hit,
   input  wire  logic               wf_hit,
   input  wire  logic               sim_wf_hit,
   input  wire  logic [3:0]         field_evaluated,
   // configuration
   input  wire  sorc_pkg::sorc_restart_t restart_mode,
   input  wire  logic               internal_outputs,
   input  wire  logic               dual_pf_mode,
   input  wire  logic               unalloc_infringed,
   input  wire  logic               fb_monitor_en,
   input  wire  logic               config_reset,
   // outputs
   output logic                     safety_output_pair,
   output sorc_pkg::sorc_link_t     safety_link,
   output logic [2:0]               case_sel,
   output logic                     case_error,
   output logic                     reset_lamp,
   output logic                     fault_lamp,
   output logic [7:0]               error_code
);
   import sorc_pkg::*;

   localparam longint DELAY_CYC = longint'(DELAY_S) * longint'(CLK_HZ);

   initial begin
      if (DELAY_S < `SORC_DELAY_MIN_S || DELAY_S > `SORC_DELAY_MAX_S)
         $error("restart delay out of range");
      if (FB_WAIT < 1)
         $error("feedback wait must be at least one cycle");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   logic rst_q1;
   logic rst_sync_n;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_q1     <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_q1     <= 1'b1;
         rst_sync_n <= rst_q1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // three-stage synchronisers for pins; a change counts once stages 2 and 3 agree
   logic [5:0] pin_raw;
   logic [5:0] s1;
   logic [5:0] s2;
   logic [5:0] s3;
   logic [5:0] pin_f;
   logic [5:0] next_pin_f;
   assign pin_raw = {case_lines, reset_switch, contactor_fb};
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : g_sync
         assign next_pin_f[g] = (s2[g] == s3[g]) ? s3[g] : pin_f[g];
      end
   endgenerate
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         s1    <= 6'h00;
         s2    <= 6'h00;
         s3    <= 6'h00;
         pin_f <= 6'h00;
      end
      else
      begin
         s1    <= pin_raw;
         s2    <= s1;
         s3    <= s2;
         pin_f <= next_pin_f;
      end
   end
   sorc_lines_t lines_f;
   logic        rst_sw;
   logic        fb_f;
   assign lines_f = pin_f[5:2];
   assign rst_sw  = pin_f[1];
   assign fb_f    = pin_f[0];

   ////////////////////////////////////////////////////////////////////////////////
   // one-hot case decode
   logic [2:0] next_case_sel;
   logic       next_case_error;
   always_comb
   begin
      next_case_sel   = 3'h0;
      next_case_error = 1'b0;
      unique case (lines_f)
         4'b1000: next_case_sel = 3'h1;
         4'b0100: next_case_sel = 3'h2;
         4'b0010: next_case_sel = 3'h3;
         4'b0001: next_case_sel = 3'h4;
         default: next_case_error = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field status mapping: clear is 1, non-evaluated per option
   logic [3:0] pf_hit;
   logic [3:0] pf_clear;
   assign pf_hit = {pf1_hit, pf2_hit, sim_pf1_hit, sim_pf2_hit};
   generate
      for (g = 0; g < 4; g++)
      begin : g_pf
         // evaluated fields report their own clear status, others follow the option
         assign pf_clear[g] = field_evaluated[g] ? ~pf_hit[g]
                                                 : ~unalloc_infringed;
      end
   endgenerate

   // active protective field for the own outputs; simultaneous field 2 excluded in dual mode
   logic active_hit;
   always_comb
   begin
      active_hit = pf1_hit;
      if (!dual_pf_mode)
         active_hit = pf1_hit | sim_pf2_hit;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // restart state machine
   sorc_state_t state;
   sorc_state_t next_state;
   longint      cnt;
   longint      next_cnt;
   logic        fb_fault;
   logic        next_fb_fault;
   logic        rst_sw_q;
   logic        rst_press;
   assign rst_press = rst_sw & ~rst_sw_q;
   always_comb
   begin
      next_state    = state;
      next_cnt      = cnt;
      next_fb_fault = fb_fault;
      unique case (state)
         SORC_ON:
         begin
            if (active_hit)
            begin
               next_state = SORC_OFF;
               next_cnt   = 0;
            end
         end
         SORC_OFF:
         begin
            // contactors must release after the trip
            next_cnt = (cnt < FB_WAIT) ? cnt + 1 : cnt;
            if (fb_monitor_en && cnt >= FB_WAIT && !fb_f)
            begin
               if (restart_mode == SORC_RST_INTERLOCK)
                  next_fb_fault = 1'b1;
               else
                  next_state = SORC_LOCK;
            end
            else if (!active_hit && (!fb_monitor_en || fb_f) && !fb_fault)
            begin
               unique case (restart_mode)
                  SORC_RST_DELAY:     begin next_state = SORC_WAIT; next_cnt = 0; end
                  SORC_RST_INTERLOCK: next_state = SORC_WAIT;
                  default:            next_state = SORC_ON;
               endcase
            end
            // reset press with clear field and released contactors clears a contactor fault and restarts
            if (fb_fault && rst_press && !active_hit && (!fb_monitor_en || fb_f))
            begin
               next_fb_fault = 1'b0;
               next_state    = SORC_ON;
            end
         end
         SORC_WAIT:
         begin
            next_cnt = cnt + 1;
            if (active_hit)
            begin
               next_state = SORC_OFF;
               next_cnt   = 0;
            end
            else if (fb_monitor_en && !fb_f)
               next_state = SORC_OFF;
            else if (restart_mode == SORC_RST_DELAY && cnt >= DELAY_CYC - 1)
               next_state = SORC_ON;
            else if (restart_mode == SORC_RST_INTERLOCK && rst_press)
               next_state = SORC_ON;
            else if (restart_mode == SORC_RST_NONE)
               next_state = SORC_ON;
         end
         SORC_LOCK:
         begin
            if (config_reset)
            begin
               next_state = SORC_OFF;
               next_cnt   = 0; // fresh feedback wait, no stale expiry
            end
         end
         default: next_state = SORC_LOCK;
      endcase
   end

   // output and link values, all registered
   logic       next_out;
   sorc_link_t next_link;
   logic [7:0] next_code;
   always_comb
   begin
      next_out = (next_state == SORC_ON) && internal_outputs;
      next_link.output_active = internal_outputs ? next_out : 1'b1;
      {next_link.pf1_clear, next_link.pf2_clear,
       next_link.sim_pf1_clear, next_link.sim_pf2_clear} = pf_clear;
      next_link.wf_clear      = ~wf_hit;
      next_link.sim_wf_clear  = ~sim_wf_hit;
      next_code = `SORC_ERR_NONE;
      if (next_state == SORC_LOCK)
         next_code = `SORC_ERR_LOCKOUT;
      else if (next_fb_fault)
         next_code = `SORC_ERR_CONTACTOR;
      else if (next_case_error)
         next_code = `SORC_ERR_SELECT;
   end

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state              <= SORC_OFF;
         cnt                <= 0;
         fb_fault           <= 1'b0;
         rst_sw_q           <= 1'b0;
         safety_output_pair <= 1'b0;
         safety_link        <= '0;
         case_sel           <= 3'h0;
         case_error         <= 1'b0;
         reset_lamp         <= 1'b0;
         fault_lamp         <= 1'b0;
         error_code         <= `SORC_ERR_NONE;
      end
      else
      begin
         state              <= next_state;
         cnt                <= next_cnt;
         fb_fault           <= next_fb_fault;
         rst_sw_q           <= rst_sw;
         safety_output_pair <= next_out;
         safety_link        <= next_link;
         case_sel           <= next_case_sel;
         case_error         <= next_case_error;
         reset_lamp         <= (next_state == SORC_WAIT) && (restart_mode == SORC_RST_INTERLOCK);
         fault_lamp         <= next_fb_fault | (next_state == SORC_LOCK);
         error_code         <= next_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_hit_off;
      @(posedge clk) disable iff (!rst_sync_n) active_hit |=> !safety_output_pair;
   endproperty
   a_hit_off: assert property (p_hit_off) else $error("output on with field hit");

   property p_lock_off;
      @(posedge clk) disable iff (!rst_sync_n)
         (state == SORC_LOCK && !config_reset) |=> (state == SORC_LOCK) && !safety_output_pair;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lock-out left without reset");

   property p_case_err;
      @(posedge clk) disable iff (!rst_sync_n) (lines_f == 4'h0) |=> case_error;
   endproperty
   a_case_err: assert property (p_case_err) else $error("missing selection error");

   property p_case_one;
      @(posedge clk) disable iff (!rst_sync_n) (lines_f == 4'b0010) |=> case_sel == 3'h3;
   endproperty
   a_case_one: assert property (p_case_one) else $error("wrong case decode");

   property p_link_active;
      @(posedge clk) disable iff (!rst_sync_n) !internal_outputs |=> safety_link.output_active;
   endproperty
   a_link_active: assert property (p_link_active) else $error("link output not active");

   property p_unalloc;
      @(posedge clk) disable iff (!rst_sync_n)
         (unalloc_infringed && !field_evaluated[3]) |=> !safety_link.pf1_clear;
   endproperty
   a_unalloc: assert property (p_unalloc) else $error("unallocated field not infringed");

   property p_interlock;
      @(posedge clk) disable iff (!rst_sync_n)
         (state == SORC_WAIT && restart_mode == SORC_RST_INTERLOCK && !rst_press)
            |=> state != SORC_ON;
   endproperty
   a_interlock: assert property (p_interlock) else $error("restart without reset switch");

   property p_dual;
      @(posedge clk) disable iff (!rst_sync_n)
         (dual_pf_mode && !pf1_hit && state == SORC_ON) |=> state == SORC_ON;
   endproperty
   a_dual: assert property (p_dual) else $error("field 2 tripped own outputs");
endmodule // sorc_top
`default_nettype wire

//--- sorc_contactor_model.sv
// partner model: machine contactors whose feedback follows the safety output pair
`timescale 1ns/1ns
`default_nettype none
module sorc_contactor_model (
   // clock
   input  wire logic clk,
   // coil drive from the safety output pair, fault command from the bench
   input  wire logic coil_on,
   input  wire logic welded,
   // feedback, high = contacts released
   output var  logic fb
);
   logic [1:0] lag;
   ////////////////////////////////////////////////////////////////////////////////
   // contacts follow the coil three cycles late; welded contacts never release
   always_ff @(posedge clk)
   begin
      lag <= {lag[0], coil_on};
      fb  <= ~(lag[1] | welded);
   end
endmodule // sorc_contactor_model
`default_nettype wire

//--- tb_top.sv
// testbench: decode, link status, restart modes and contactor faults
`timescale 1ns/1ns
`default_nettype none
`include "sorc_map.svh"
module tb_top;
   import sorc_pkg::*;
   logic                clk;
   logic                rst_n;
   sorc_lines_t         case_lines;
   logic                reset_switch, contactor_fb, welded;
   logic                pf1_hit, pf2_hit, sim_pf1_hit, sim_pf2_hit, wf_hit, sim_wf_hit;
   logic [3:0]          field_evaluated, h;
   sorc_restart_t       restart_mode;
   logic                internal_outputs, dual_pf_mode, unalloc_infringed;
   logic                fb_monitor_en, config_reset;
   logic                safety_output_pair, case_error, reset_lamp, fault_lamp;
   sorc_link_t          safety_link;
   logic [2:0]          case_sel;
   logic [7:0]          error_code;
   int                  n_fail, comparisons, cycles, i;
   ////////////////////////////////////////////////////////////////////////////////
   // short counts: restart delay 20 cycles, feedback wait 16 cycles (beyond fb latency)
   sorc_top #(.DELAY_S(2), .CLK_HZ(10), .FB_WAIT(16)) DUT (
      .clk(clk), .rst_n(rst_n), .case_lines(case_lines), .reset_switch(reset_switch),
      .contactor_fb(contactor_fb), .pf1_hit(pf1_hit), .pf2_hit(pf2_hit),
      .sim_pf1_hit(sim_pf1_hit), .sim_pf2_hit(sim_pf2_hit), .wf_hit(wf_hit),
      .sim_wf_hit(sim_wf_hit), .field_evaluated(field_evaluated),
      .restart_mode(restart_mode), .internal_outputs(internal_outputs),
      .dual_pf_mode(dual_pf_mode), .unalloc_infringed(unalloc_infringed),
      .fb_monitor_en(fb_monitor_en), .config_reset(config_reset),
      .safety_output_pair(safety_output_pair), .safety_link(safety_link),
      .case_sel(case_sel), .case_error(case_error), .reset_lamp(reset_lamp),
      .fault_lamp(fault_lamp), .error_code(error_code));
   sorc_contactor_model PARTNER (.clk(clk), .coil_on(safety_output_pair),
      .welded(welded), .fb(contactor_fb));
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // expected case number of one-hot lines, 0 on error
   function automatic logic [7:0] exp_sel(input logic [3:0] l);
      case (l)
         4'b1000: return 8'h01;
         4'b0100: return 8'h02;
         4'b0010: return 8'h03;
         4'b0001: return 8'h04;
         default: return 8'h00;
      endcase
   endfunction
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   // wait a bounded time for the output pair, then compare
   task automatic expect_out(input logic v, input int lim);
      int k;
      k = 0;
      while (safety_output_pair !== v && k < lim)
      begin
         @(negedge clk);
         k++;
      end
      check("output_pair", {7'h0, v}, {7'h0, safety_output_pair});
   endtask
   // press the reset switch for 8 cycles, then release it for 2
   task automatic press();
      reset_switch = 1'b1;
      step(8);
      reset_switch = 1'b0;
      step(2);
   endtask
   task automatic close_out();
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      n_fail = 0; comparisons = 0; cycles = 0;
      rst_n = 1'b0; case_lines = 4'b1000; reset_switch = 1'b0; welded = 1'b0;
      {pf1_hit, pf2_hit, sim_pf1_hit, sim_pf2_hit, wf_hit, sim_wf_hit} = 6'h00;
      field_evaluated = 4'hf; restart_mode = SORC_RST_NONE; internal_outputs = 1'b1;
      dual_pf_mode = 1'b0; unalloc_infringed = 1'b0; fb_monitor_en = 1'b1;
      config_reset = 1'b0;
      void'($urandom(58638));
      step(6);
      rst_n = 1'b1;
      step(4);
      for (i = 0; i < 40; i++)
      begin
         case_lines = (i < 16) ? 4'(i) : 4'($urandom);
         step(8);
         check("case_sel", exp_sel(case_lines), {5'h0, case_sel});
         check("case_error", {7'h0, exp_sel(case_lines) == 8'h0}, {7'h0, case_error});
      end
      case_lines = 4'b1000;
      for (i = 0; i < 30; i++)
      begin
         {pf1_hit, pf2_hit, sim_pf1_hit, sim_pf2_hit, wf_hit, sim_wf_hit} = 6'($urandom);
         field_evaluated = 4'($urandom);
         unalloc_infringed = 1'($urandom);
         internal_outputs = 1'($urandom);
         step(3);
         h = {pf1_hit, pf2_hit, sim_pf1_hit, sim_pf2_hit};
         check("pf_clear", {4'h0, (field_evaluated & ~h) | (~field_evaluated
            & {4{~unalloc_infringed}})}, {4'h0, safety_link.pf1_clear, safety_link.pf2_clear,
            safety_link.sim_pf1_clear, safety_link.sim_pf2_clear});
         check("wf_clear", {6'h0, ~wf_hit, ~sim_wf_hit},
            {6'h0, safety_link.wf_clear, safety_link.sim_wf_clear});
         if (internal_outputs == 1'b0)
            check("output_active", 8'h01, {7'h0, safety_link.output_active});
         else
            check("output_active", {7'h0, safety_output_pair},
               {7'h0, safety_link.output_active});
      end
      {pf1_hit, pf2_hit, sim_pf1_hit, sim_pf2_hit, wf_hit, sim_wf_hit} = 6'h00;
      field_evaluated = 4'hf; unalloc_infringed = 1'b0; internal_outputs = 1'b1;
      expect_out(1'b1, 40);
      pf1_hit = 1'b1;
      expect_out(1'b0, 3);
      pf1_hit = 1'b0;
      expect_out(1'b1, 20);
      // simultaneous field 2 leaves the own pair alone in dual mode
      sim_pf2_hit = 1'b1; dual_pf_mode = 1'b1;
      step(6);
      check("dual_mode_out", 8'h01, {7'h0, safety_output_pair});
      dual_pf_mode = 1'b0;
      expect_out(1'b0, 3);
      sim_pf2_hit = 1'b0;
      expect_out(1'b1, 20);
      restart_mode = SORC_RST_DELAY;
      pf1_hit = 1'b1;
      expect_out(1'b0, 3);
      pf1_hit = 1'b0;
      step(12);
      check("delay_early", 8'h00, {7'h0, safety_output_pair});
      expect_out(1'b1, 30);
      restart_mode = SORC_RST_INTERLOCK;
      pf1_hit = 1'b1;
      expect_out(1'b0, 3);
      pf1_hit = 1'b0;
      step(40);
      check("interlock_hold", 8'h00, {7'h0, safety_output_pair});
      check("reset_lamp", 8'h01, {7'h0, reset_lamp});
      reset_switch = 1'b1;
      expect_out(1'b1, 8);
      reset_switch = 1'b0;
      // welded contactor without interlock: full lock-out
      restart_mode = SORC_RST_NONE;
      pf1_hit = 1'b1; welded = 1'b1;
      step(20);
      pf1_hit = 1'b0;
      step(20);
      check("lock_code", `SORC_ERR_LOCKOUT, error_code);
      check("lock_out", 8'h00, {7'h0, safety_output_pair});
      press();
      check("lock_ignores_reset", 8'h00, {7'h0, safety_output_pair});
      welded = 1'b0; config_reset = 1'b1;
      step(2);
      config_reset = 1'b0;
      expect_out(1'b1, 30);
      // welded contactor with interlock: fault, lamp, off
      restart_mode = SORC_RST_INTERLOCK;
      pf1_hit = 1'b1; welded = 1'b1;
      step(20);
      check("fault_code", `SORC_ERR_CONTACTOR, error_code);
      check("fault_lamp", 8'h01, {7'h0, fault_lamp});
      welded = 1'b0; pf1_hit = 1'b0;
      step(10);
      press();
      expect_out(1'b1, 12);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
